// File: hw/occs_pkg.sv
// Constants, register map and source decode for the clock selector.
// Assumes a 32-bit APB slave with byte addresses, one word per register.
package occs_pkg;

  // Register byte addresses
  localparam int unsigned     APB_AW    = 12;
  localparam logic [11:0]     ADDR_CTRL = 12'h000;
  localparam logic [11:0]     ADDR_STAT = 12'h004;
  localparam logic [11:0]     ADDR_CFG  = 12'h008;

  // Control register fields
  localparam int unsigned     CTRL_SCS_LSB  = 0;
  localparam int unsigned     CTRL_IRCF_LSB = 3;
  localparam logic [1:0]      SCS_RESET     = 2'h0;
  localparam logic [3:0]      IRCF_RESET    = 4'h7;
  localparam logic [1:0]      SCS_PRIMARY   = 2'h0;
  localparam logic [1:0]      SCS_SECONDARY = 2'h1;

  // Status register bit positions
  localparam int unsigned     STAT_SLOW_RDY = 0;
  localparam int unsigned     STAT_FAST_STB = 1;
  localparam int unsigned     STAT_SEC_RDY  = 2;
  localparam int unsigned     STAT_XTAL_RUN = 3;
  localparam int unsigned     STAT_FAST_RDY = 4;

  // Configuration register fields (stand-in for the configuration word)
  localparam int unsigned     CFG_MODE_LSB  = 0;
  localparam int unsigned     CFG_CLKOUT    = 3;
  localparam int unsigned     CFG_TWO_SPEED = 4;
  localparam int unsigned     CFG_FAILMON   = 5;
  localparam int unsigned     CFG_PWRDLY    = 6;
  localparam int unsigned     CFG_W         = 7;
  localparam logic [6:0]      CFG_RESET_DEFAULT = 7'h04;

  // Oscillator configuration modes
  localparam logic [2:0]      MODE_LOW_GAIN  = 3'h0;
  localparam logic [2:0]      MODE_MED_GAIN  = 3'h1;
  localparam logic [2:0]      MODE_HIGH_GAIN = 3'h2;
  localparam logic [2:0]      MODE_EXT_RC    = 3'h3;
  localparam logic [2:0]      MODE_INTERNAL  = 3'h4;

  // Crystal start-up oscillation count
  localparam int unsigned     XTAL_STARTUP_EDGES = 1024;
  localparam int unsigned     FAST_DIV_W         = 9;

  typedef enum logic [1:0] {
    SRC_NONE, SRC_PRIMARY, SRC_SECONDARY, SRC_INTERNAL
  } occs_src_t;

  // Codes 0000 and 0001 pick the slow oscillator
  function automatic logic occs_ircf_slow(input logic [3:0] f);
    return f[3:1] == 3'h0;
  endfunction

  // Power of two dividing the fast oscillator for each code
  function automatic logic [3:0] occs_ircf_div(input logic [3:0] f);
    case (f)
      4'hF: return 4'h0;
      4'hE: return 4'h1;
      4'hD: return 4'h2;
      4'hC: return 4'h3;
      4'hB: return 4'h4;
      4'hA, 4'h7: return 4'h5;
      4'h9, 4'h6: return 4'h6;
      4'h8, 4'h5: return 4'h7;
      4'h4: return 4'h8;
      default: return 4'h9;
    endcase
  endfunction

endpackage

// File: hw/occs_edge_mon.sv
// Synchroniser and edge counter for one free-running oscillator input.
// Assumes the oscillator is much slower than pclk.
`timescale 1ns/1ps
module occs_edge_mon #(
  parameter int unsigned TARGET = 1
) (
  // Clock and control
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic clear,
  // Oscillator
  input  wire logic async_in,
  // Results
  output logic      level,
  output logic      rise,
  output logic      seen,
  output logic      reached
);
  localparam int unsigned CW = $clog2(TARGET + 1);
  localparam logic [CW-1:0] TGT = CW'(TARGET);

  if (TARGET < 1) begin : g_chk
    $error("occs_edge_mon: TARGET must be at least 1");
  end

  logic          sync1_ff;
  logic          sync2_ff;
  logic          prev_ff;
  logic [CW-1:0] cnt_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff  <= 1'b0;
    end else if (ce) begin
      sync1_ff <= async_in;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  // Saturates so a long-running oscillator never wraps back to not-ready
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (ce) begin
      if (clear) begin
        cnt_ff <= '0;
      end else if (rise && cnt_ff != TGT) begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  assign level   = sync2_ff;
  assign rise    = sync2_ff & ~prev_ff;
  assign seen    = cnt_ff != '0;
  assign reached = cnt_ff == TGT;
endmodule

// File: hw/occs_top.sv
// System clock source control with APB registers and glitch-free switch.
// Assumes oscillator outputs arrive as asynchronous levels well below pclk;
// the system clock is rebuilt in the pclk domain from sampled levels.
`timescale 1ns/1ps
// Behaviour
// - Crystal modes count 1024 oscillations before use
// - Count starts after power delay, and wake-up
// - Hold CPU while counting unless monitor/two-speed
// - Secondary crystal selectable as run-time clock
// - Config bit picks clock-out or GPIO pin
// - Internal mode frees primary input pin
// - Internal config means internal clock after reset
// - Fast oscillator runs for fast internal selections
// - Slow oscillator runs when selected or needed
// - Slow oscillator ticks timers and monitor
// - Status bit shows fast oscillator running
// - Status bit shows fast oscillator settled
// - Status bit shows slow oscillator running
// - Frequency field picks divided or slow source
// - Frequency field resets to 0111
// - Duplicate frequency codes on same or other source
// - Switch: start, wait fall, hold low, rise
// - Same-source frequency change skips start-up delay
// - Status register tracks both oscillators live
// - Software selects among three clock sources
// - Select 00 config, 01 secondary, 1x internal
// - Source select clears on every reset
module occs_top
  import occs_pkg::*;
#(
  parameter int unsigned FAST_STABLE_EDGES = 64,
  parameter logic [6:0]  CFG_RESET         = CFG_RESET_DEFAULT
) (
  // Clock, reset, enable
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Oscillator inputs
  input  wire logic              primary_osc_input,
  input  wire logic              secondary_crystal_in,
  input  wire logic              fast_internal_osc,
  input  wire logic              slow_internal_osc,
  // Power state
  input  wire logic              sleep_active,
  input  wire logic              powerup_delay_done,
  input  wire logic              powerup_delay_busy,
  input  wire logic              watchdog_timer_enable,
  // Clock and control outputs
  output logic                   sys_clk,
  output logic                   cpu_hold,
  output logic                   fast_osc_en,
  output logic                   slow_osc_en,
  output logic                   slow_osc_tick,
  output logic                   primary_in_gpio,
  output logic                   primary_osc_output_o,
  output logic                   primary_osc_output_oe
);

  if (FAST_STABLE_EDGES < 1) begin : g_chk
    $error("occs_top: FAST_STABLE_EDGES must be at least 1");
  end

  // All checks run on pclk and rest while reset is asserted
  default clocking chk_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  typedef enum logic [1:0] {XS_WAIT_PWR, XS_COUNT, XS_DONE, XS_SLEEP}
    occs_xs_t;
  typedef enum logic [1:0] {SW_IDLE, SW_START, SW_FALL, SW_RISE}
    occs_sw_t;

  logic [1:0]       scs_ff;
  logic [3:0]       ircf_ff;
  logic [CFG_W-1:0] cfg_ff;
  occs_xs_t         xs_ff;
  occs_sw_t         sw_ff;
  occs_src_t        cur_kind_ff;
  logic [3:0]       cur_ircf_ff;
  occs_src_t        pend_kind_ff;
  logic [3:0]       pend_ircf_ff;
  logic             cur_lvl_ff;
  logic             new_lvl_ff;
  logic [FAST_DIV_W-1:0] fast_div_ff;
  logic             sleep_ff;

  logic prim_lvl, prim_done;
  logic sec_lvl, sec_seen;
  logic fast_lvl, fast_rise, fast_seen, fast_stable;
  logic slow_lvl, slow_rise, slow_seen;

  // Oscillator monitors
  occs_edge_mon #(.TARGET(XTAL_STARTUP_EDGES)) u_prim (
    .clk(pclk), .rst_n(presetn), .ce(ce), .clear(xs_ff != XS_COUNT),
    .async_in(primary_osc_input), .level(prim_lvl), .rise(),
    .seen(), .reached(prim_done));
  occs_edge_mon #(.TARGET(1)) u_sec (
    .clk(pclk), .rst_n(presetn), .ce(ce), .clear(1'b0),
    .async_in(secondary_crystal_in), .level(sec_lvl), .rise(),
    .seen(sec_seen), .reached());
  occs_edge_mon #(.TARGET(FAST_STABLE_EDGES)) u_fast (
    .clk(pclk), .rst_n(presetn), .ce(ce), .clear(~fast_osc_en),
    .async_in(fast_internal_osc), .level(fast_lvl), .rise(fast_rise),
    .seen(fast_seen), .reached(fast_stable));
  occs_edge_mon #(.TARGET(1)) u_slow (
    .clk(pclk), .rst_n(presetn), .ce(ce), .clear(~slow_osc_en),
    .async_in(slow_internal_osc), .level(slow_lvl), .rise(slow_rise),
    .seen(slow_seen), .reached());

  logic [2:0] mode;
  logic       xtal_mode;
  logic       early_run;
  logic       apb_access;
  assign mode       = cfg_ff[CFG_MODE_LSB +: 3];
  assign xtal_mode  = mode == MODE_LOW_GAIN || mode == MODE_MED_GAIN ||
                      mode == MODE_HIGH_GAIN;
  assign early_run  = cfg_ff[CFG_TWO_SPEED] | cfg_ff[CFG_FAILMON];
  assign apb_access = psel & penable & pready;

  // APB: one wait state, answer registered in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (ce) begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel & penable & ~pready) begin
        case (paddr)
          ADDR_CTRL: begin
            prdata[CTRL_SCS_LSB +: 2]  <= scs_ff;
            prdata[CTRL_IRCF_LSB +: 4] <= ircf_ff;
          end
          ADDR_STAT: begin
            prdata[STAT_FAST_RDY] <= fast_seen;
            prdata[STAT_FAST_STB] <= fast_stable;
            prdata[STAT_SLOW_RDY] <= slow_seen;
            prdata[STAT_SEC_RDY]  <= sec_seen;
            prdata[STAT_XTAL_RUN] <= cur_kind_ff == SRC_PRIMARY && xtal_mode;
          end
          ADDR_CFG: prdata[CFG_W-1:0] <= cfg_ff;
          default:  pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scs_ff  <= SCS_RESET;
      ircf_ff <= IRCF_RESET;
    end else if (ce && apb_access && pwrite && paddr == ADDR_CTRL) begin
      scs_ff  <= pwdata[CTRL_SCS_LSB +: 2];
      ircf_ff <= pwdata[CTRL_IRCF_LSB +: 4];
    end
  end

  // Configuration word image; a write takes effect on the next cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= CFG_RESET;
    end else if (ce && apb_access && pwrite && paddr == ADDR_CFG) begin
      cfg_ff <= pwdata[CFG_W-1:0];
    end
  end

  // Crystal start-up sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xs_ff    <= XS_WAIT_PWR;
      sleep_ff <= 1'b0;
    end else if (ce) begin
      sleep_ff <= sleep_active;
      case (xs_ff)
        XS_WAIT_PWR: begin
          if (powerup_delay_done || !cfg_ff[CFG_PWRDLY]) begin
            xs_ff <= XS_COUNT;
          end
        end
        XS_COUNT: begin
          if (sleep_active) begin
            xs_ff <= XS_SLEEP;
          end else if (prim_done) begin
            xs_ff <= XS_DONE;
          end
        end
        XS_DONE: begin
          if (sleep_active) begin
            xs_ff <= XS_SLEEP;
          end
        end
        XS_SLEEP: begin
          if (sleep_ff && !sleep_active) begin
            xs_ff <= XS_COUNT;
          end
        end
        default: xs_ff <= XS_WAIT_PWR;
      endcase
    end
  end

  logic xtal_ok;
  assign xtal_ok = !xtal_mode || xs_ff == XS_DONE;

  // CPU hold while the crystal is unproven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_hold <= 1'b1;
    end else if (ce) begin
      cpu_hold <= !xtal_ok && !early_run;
    end
  end

  // Target source
  occs_src_t tgt_kind;
  logic [3:0] tgt_ircf;
  always_comb begin
    tgt_kind = SRC_INTERNAL;
    tgt_ircf = ircf_ff;
    if (scs_ff == SCS_SECONDARY) begin
      tgt_kind = SRC_SECONDARY;
    end else if (scs_ff == SCS_PRIMARY) begin
      if (mode == MODE_INTERNAL) begin
        tgt_kind = SRC_INTERNAL;
      end else if (xtal_ok) begin
        tgt_kind = SRC_PRIMARY;
      end else if (!early_run) begin
        tgt_kind = SRC_NONE;
      end
    end
    if (tgt_kind != SRC_INTERNAL) begin
      tgt_ircf = '0;
    end
  end

  // Fast oscillator divider chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_div_ff <= '0;
    end else if (ce && fast_rise) begin
      fast_div_ff <= fast_div_ff + 1'b1;
    end
  end

  // Sampled level of a source; both codes per frequency share the chain
  function automatic logic src_level(input occs_src_t k,
                                     input logic [3:0] f);
    logic [3:0] d;
    d = occs_ircf_div(f);
    case (k)
      SRC_PRIMARY:   return prim_lvl;
      SRC_SECONDARY: return sec_lvl;
      SRC_INTERNAL: begin
        if (occs_ircf_slow(f)) begin
          return slow_lvl;
        end else if (d == 4'h0) begin
          return fast_lvl;
        end
        return fast_div_ff[d - 4'h1];
      end
      default:       return 1'b0;
    endcase
  endfunction

  function automatic logic src_ready(input occs_src_t k,
                                     input logic [3:0] f);
    case (k)
      // The edge counter clears once done, so readiness is the count state
      SRC_PRIMARY:   return xtal_ok;
      SRC_SECONDARY: return sec_seen;
      SRC_INTERNAL:  return occs_ircf_slow(f) ? slow_seen : fast_seen;
      default:       return 1'b1;
    endcase
  endfunction

  logic cur_lvl;
  logic new_lvl;
  logic new_ready;
  always_comb begin
    cur_lvl   = src_level(cur_kind_ff, cur_ircf_ff);
    new_lvl   = src_level(pend_kind_ff, pend_ircf_ff);
    new_ready = src_ready(pend_kind_ff, pend_ircf_ff);
  end

  // Glitch-free switch between sources
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_ff        <= SW_IDLE;
      cur_kind_ff  <= SRC_NONE;
      cur_ircf_ff  <= '0;
      pend_kind_ff <= SRC_NONE;
      pend_ircf_ff <= '0;
      cur_lvl_ff   <= 1'b0;
      new_lvl_ff   <= 1'b0;
    end else if (ce) begin
      cur_lvl_ff <= cur_lvl;
      new_lvl_ff <= new_lvl;
      case (sw_ff)
        SW_IDLE: begin
          if (tgt_kind != cur_kind_ff || tgt_ircf != cur_ircf_ff) begin
            pend_kind_ff <= tgt_kind;
            pend_ircf_ff <= tgt_ircf;
            sw_ff        <= SW_START;
          end
        end
        SW_START: begin
          // A running source passes at once, so same-source moves skip it
          if (new_ready) begin
            sw_ff <= SW_FALL;
          end
        end
        SW_FALL: begin
          if ((cur_lvl_ff && !cur_lvl) || cur_kind_ff == SRC_NONE) begin
            sw_ff <= SW_RISE;
          end
        end
        SW_RISE: begin
          if ((!new_lvl_ff && new_lvl) || pend_kind_ff == SRC_NONE) begin
            cur_kind_ff <= pend_kind_ff;
            cur_ircf_ff <= pend_ircf_ff;
            sw_ff       <= SW_IDLE;
          end
        end
        default: sw_ff <= SW_IDLE;
      endcase
    end
  end

  // System clock rebuilt from the active source, held low in SW_RISE while waiting for the new source's rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clk <= 1'b0;
    end else if (ce) begin
      sys_clk <= (sw_ff == SW_RISE) ? 1'b0 : cur_lvl;
    end
  end

  // Oscillator enables; the one in use stays on until the switch ends
  logic int_req;
  logic use_fast;
  logic use_slow;
  assign int_req  = mode == MODE_INTERNAL || scs_ff[1];
  assign use_fast = (cur_kind_ff == SRC_INTERNAL &&
                     !occs_ircf_slow(cur_ircf_ff)) ||
                    (pend_kind_ff == SRC_INTERNAL && sw_ff != SW_IDLE &&
                     !occs_ircf_slow(pend_ircf_ff));
  assign use_slow = (cur_kind_ff == SRC_INTERNAL &&
                     occs_ircf_slow(cur_ircf_ff)) ||
                    (pend_kind_ff == SRC_INTERNAL && sw_ff != SW_IDLE &&
                     occs_ircf_slow(pend_ircf_ff));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_osc_en   <= 1'b0;
      slow_osc_en   <= 1'b0;
      slow_osc_tick <= 1'b0;
    end else if (ce) begin
      fast_osc_en   <= (int_req && !occs_ircf_slow(ircf_ff)) ||
                       use_fast;
      slow_osc_en   <= (int_req && occs_ircf_slow(ircf_ff)) || use_slow ||
                       powerup_delay_busy || watchdog_timer_enable ||
                       cfg_ff[CFG_FAILMON];
      slow_osc_tick <= slow_rise;
    end
  end

  // Pin ownership; crystal modes leave both pins to the amplifier
  logic clkout_allowed;
  assign clkout_allowed = (mode == MODE_EXT_RC || mode == MODE_INTERNAL) &&
                          cfg_ff[CFG_CLKOUT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_in_gpio       <= 1'b0;
      primary_osc_output_o  <= 1'b0;
      primary_osc_output_oe <= 1'b0;
    end else if (ce) begin
      primary_in_gpio       <= mode == MODE_INTERNAL;
      primary_osc_output_o  <= clkout_allowed & sys_clk;
      primary_osc_output_oe <= clkout_allowed;
    end
  end

  // Checks
  count_done_a: assert property ($rose(xs_ff == XS_DONE) |->
    $past(prim_done)) else $error("start-up done without 1024 edges");
  hold_cpu_a: assert property (ce && !xtal_ok && !early_run |=>
    cpu_hold) else $error("cpu not held during start-up count");
  release_cpu_a: assert property (ce && xtal_ok |=> !cpu_hold)
    else $error("cpu still held after count");
  reset_sel_a: assert property ($rose(presetn) |->
    ircf_ff == IRCF_RESET && scs_ff == SCS_RESET)
    else $error("control register reset value wrong");
  fast_en_a: assert property (
    ce && int_req && !occs_ircf_slow(ircf_ff) |=> fast_osc_en)
    else $error("fast oscillator not enabled");
  slow_en_a: assert property (ce && watchdog_timer_enable |=>
    slow_osc_en) else $error("slow oscillator not enabled for timer");
  hold_low_a: assert property (ce && sw_ff == SW_RISE |=>
    !sys_clk) else $error("system clock not held low in handover");
  // A move within one oscillator must not wait for a start-up
  same_src_a: assert property (
    ce && sw_ff == SW_START && cur_kind_ff == SRC_INTERNAL &&
    pend_kind_ff == SRC_INTERNAL &&
    occs_ircf_slow(cur_ircf_ff) == occs_ircf_slow(pend_ircf_ff) |=>
    sw_ff == SW_FALL) else $error("start-up delay on running source");
  pin_free_a: assert property (ce && mode == MODE_INTERNAL |=>
    primary_in_gpio) else $error("primary pin not released");
  stat_read_a: assert property (
    ce && psel && penable && !pready && paddr == ADDR_STAT |=>
    prdata[STAT_FAST_RDY] == $past(fast_seen) &&
    prdata[STAT_SLOW_RDY] == $past(slow_seen))
    else $error("status read does not match oscillators");
endmodule

// File: bench/occs_osc_model.sv
// Oscillator sources seen by the clock selector.
// Assumes the selector's enables gate the two internal oscillators.
`timescale 1ns/1ps
module occs_osc_model (
  // Run enables
  input  wire logic fast_osc_en,
  input  wire logic slow_osc_en,
  // Oscillator levels
  output logic      primary_osc_input,
  output logic      secondary_crystal_in,
  output logic      fast_internal_osc,
  output logic      slow_internal_osc
);
  // All periods stay above four pclk cycles so no edge is lost
  initial begin
    primary_osc_input = 1'b0;
    secondary_crystal_in = 1'b0;
    fast_internal_osc = 1'b0;
    slow_internal_osc = 1'b0;
  end
  always #40 primary_osc_input = !primary_osc_input;
  always #70 secondary_crystal_in = !secondary_crystal_in;
  // A stopped oscillator rests low
  always #30 fast_internal_osc = fast_osc_en && !fast_internal_osc;
  always #110 slow_internal_osc = slow_osc_en && !slow_internal_osc;
endmodule

// File: bench/testbench.sv
// Self-checking bench for the clock selector.
// Assumes one pclk domain and the APB map of the package.
`timescale 1ns/1ps
module testbench;
  import occs_pkg::*;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0;
  logic pwrite = 0, sleep_active = 0, powerup_delay_done = 1;
  logic powerup_delay_busy = 0, watchdog_timer_enable = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, sys_clk, cpu_hold, fast_osc_en, slow_osc_en;
  logic slow_osc_tick, primary_in_gpio, primary_osc_output_o, err;
  logic primary_osc_output_oe, primary_osc_input, secondary_crystal_in;
  logic fast_internal_osc, slow_internal_osc, p0;
  logic [3:0] f;
  int n_fail = 0, check_count = 0, n, k;

  occs_top #(.FAST_STABLE_EDGES(4)) dut_u (.pclk, .presetn, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .primary_osc_input, .secondary_crystal_in, .fast_internal_osc,
    .slow_internal_osc, .sleep_active, .powerup_delay_done,
    .powerup_delay_busy, .watchdog_timer_enable, .sys_clk, .cpu_hold,
    .fast_osc_en, .slow_osc_en, .slow_osc_tick, .primary_in_gpio,
    .primary_osc_output_o, .primary_osc_output_oe);
  occs_osc_model osc_u (.fast_osc_en, .slow_osc_en, .primary_osc_input,
    .secondary_crystal_in, .fast_internal_osc, .slow_internal_osc);

  always #5 pclk = !pclk;

  function automatic logic slow_code(input logic [3:0] c);
    return c[3:1] == 3'h0;
  endfunction

  task automatic chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_fail++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Counts system clock changes; the clock-out pin lags it by one edge
  task automatic toggles(input int cyc, input logic ck);
    n = 0;
    repeat (cyc) begin
      p0 = sys_clk;
      @(posedge pclk);
      if (sys_clk !== p0) n++;
      chk("clk_out", primary_osc_output_o, ck & p0);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #500us;
    n_fail++;
    complete_run();
  end

  initial begin
    void'($urandom(48049));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, ADDR_CTRL, 0);
    chk("ctrl_reset", q, 32'h38);
    chk("pin_gpio", primary_in_gpio, 1);
    toggles(400, 1'b0);
    chk("default_int", n > 0, 1);
    apb(1, ADDR_CFG, 32'h0C);
    @(posedge pclk);
    chk("clk_out_oe", primary_osc_output_oe, 1);
    for (int i = 0; i < 10; i++) begin
      f = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom);
      watchdog_timer_enable <= 1'($urandom);
      apb(1, ADDR_CTRL, {25'h0, f, 3'h2});
      apb(0, ADDR_CTRL, 0);
      chk("ctrl_rb", q, {25'h0, f, 3'h2});
      k = 0;
      repeat (40) begin
        @(posedge pclk);
        if (slow_osc_tick === 1'b1) k++;
      end
      apb(0, ADDR_STAT, 0);
      if (slow_code(f)) begin
        chk("slow_en", slow_osc_en, 1);
        chk("slow_tick", k > 0, 1);
        chk("slow_rdy", q[STAT_SLOW_RDY], 1);
      end else begin
        chk("fast_en", fast_osc_en, 1);
        chk("fast_rdy", q[STAT_FAST_RDY], 1);
        chk("fast_stb", q[STAT_FAST_STB], 1);
      end
    end
    apb(1, ADDR_CTRL, 32'h39);
    // Pending handovers from the slowest dividers can take tens of us
    toggles(12000, 1'b1);
    chk("secondary", n > 20, 1);
    apb(0, 12'h00C, 0);
    chk("unmapped", err, 1);
    apb(1, ADDR_CTRL, 32'h38);
    apb(1, ADDR_CFG, {29'h0, MODE_MED_GAIN});
    sleep_active <= 1'b1;
    // The synchroniser lets the design count an edge from before wake-up
    repeat (4) @(posedge pclk);
    p0 = primary_osc_input;
    @(posedge pclk);
    sleep_active <= 1'b0;
    k = 0;
    n = 0;
    while (cpu_hold === 1'b1 && k < 20000) begin
      @(posedge pclk);
      k++;
      if (primary_osc_input && !p0) n++;
      p0 = primary_osc_input;
    end
    chk("cpu_held", k > 3, 1);
    chk("xtal_count", n >= 1024 && n <= 1027, 1);
    // Let the handover to the crystal finish before reading status
    repeat (40) @(posedge pclk);
    apb(0, ADDR_STAT, 0);
    chk("xtal_run", q[STAT_XTAL_RUN], 1);
    complete_run();
  end
endmodule
